// >>> include/rtcwd_pkg.sv
// shared constants for the real-time clock, alarm, watchdog and irq block
package rtcwd_pkg;
	// ------------------------------
	// counter widths
	// ------------------------------
	localparam int SEC_W   = 32;           // seconds counter width
	localparam int SUB_W   = 8;            // subsecond counter width
	localparam int ALARM_W = 20;           // alarm match width
	// ------------------------------
	// tick generation
	// ------------------------------
	localparam int XTAL_HZ  = 32768;       // crystal frequency
	localparam int TICK_HZ  = 256;         // subsecond tick rate
	localparam int XTAL_DIV = XTAL_HZ / TICK_HZ;  // crystal edges per tick
	// ------------------------------
	// times in ms, counted in 256 Hz ticks
	// ------------------------------
	localparam int WDOG_MS    = 500;       // service interval
	localparam int WRST_MS    = 250;       // reset pulse length
	localparam int POR_MS     = 1500;      // reset release delay
	localparam int QUARTER_MS = 250;       // watchdog count granule
	localparam int WRST_TICKS = WRST_MS * TICK_HZ / 1000;
	localparam int POR_TICKS  = POR_MS * TICK_HZ / 1000;
	localparam int WDOG_QTRS  = WDOG_MS / QUARTER_MS;
	localparam int QTR_TICKS  = QUARTER_MS * TICK_HZ / 1000;
	// ------------------------------
	// status and mask bit positions
	// ------------------------------
	localparam int ST_W        = 6;        // number of status flags
	localparam int ST_CONV     = 0;        // conversion_ready
	localparam int ST_ALARM    = 1;        // alarm_flag
	localparam int ST_PIN_RISE = 2;        // user_pin rising edge
	localparam int ST_PIN_FALL = 3;        // user_pin falling edge
	localparam int ST_DSUP_LOW = 4;        // digital_supply_low_flag
	localparam int ST_PUMP_LOW = 5;        // pump_output_low_flag
	// ------------------------------
	// reset values
	// ------------------------------
	localparam logic [ST_W-1:0] MASK_RST = 6'h01;  // conversion only
	localparam logic            POL_RST  = 1'b0;   // active high
	localparam logic            HYS_RST  = 1'b0;   // hysteresis select
endpackage

// >>> tb/rtcwd_host.sv
// host model: services the watchdog while running, held by reset
`timescale 1ns/100ps
`default_nettype none
module rtcwd_host (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// service control and device reset
	input  wire logic        svcEn,
	input  wire logic [15:0] svcGap,
	input  wire logic        resetOut,
	output logic             watchdogService
);
	int unsigned gap;                         // clocks since last write
	// a host in reset cannot service
	always @(negedge clock) begin
		if (!rst_n || !svcEn || resetOut) begin
			watchdogService <= 1'b0;
			gap <= 0;
		end else begin
			gap <= (gap >= svcGap) ? 0 : gap + 1;
			watchdogService <= (gap >= svcGap);
		end
	end
endmodule
`default_nettype wire

// >>> tb/rtcwd_top_bench.sv
// self-checking bench for the rtc, alarm, watchdog and irq block
`timescale 1ns/100ps
`default_nettype none
module rtcwd_top_bench;
	// ------------------------------
	// signals and counters
	// ------------------------------
	localparam int TK = 16;                   // clocks per 256 Hz tick
	localparam int TW = 0, AMW = 1, AEW = 2, SLP = 3, WEW = 4;
	localparam int SCW = 5, CNV = 6, MW = 7, PW = 8;
	logic        clock, rst_n, xtalIn, svcEn, svc;
	logic [8:0]  stb;                         // one-cycle strobes
	logic [31:0] secIn, timeSec, s;
	logic [7:0]  subIn, timeSub, b;
	logic [19:0] almIn, almOut;
	logic [5:0]  clr, mskIn, flags, mask;
	logic [15:0] svcGap, rnd;
	logic        almEnIn, wdEnIn, dLow, pLow, hysIn, pin, polIn;
	logic        alarmEnable, sleepMode, wdBit, hysOut, resetOut, irq;
	int          fail_count, checks, n, m;
	int          srcList [5] = '{0, 3, 2, 4, 5};
	rtcwd_top #(.XTAL_DIV(4), .POR_TICKS(3), .WRST_TICKS(2)) uut (
		.clock(clock), .rst_n(rst_n), .xtalIn(xtalIn),
		.timeWrite(stb[TW]), .timeSecIn(secIn), .timeSubIn(subIn),
		.timeSec(timeSec), .timeSub(timeSub),
		.alarmMatchWrite(stb[AMW]), .alarmMatchIn(almIn),
		.alarmEnableWrite(stb[AEW]), .alarmEnableIn(almEnIn),
		.alarmSecondsMatch(almOut), .alarmEnable(alarmEnable),
		.sleepEnter(stb[SLP]), .sleepMode(sleepMode),
		.watchdogEnableWrite(stb[WEW]), .watchdogEnableIn(wdEnIn),
		.watchdogService(svc), .watchdogEnableBit(wdBit),
		.digitalSupplyLow(dLow), .pumpOutputLow(pLow),
		.supervisorConfigWrite(stb[SCW]), .hysteresisSelectIn(hysIn),
		.hysteresisSelect(hysOut), .resetOut(resetOut),
		.conversionReady(stb[CNV]), .userPin(pin),
		.statusClear(clr), .statusFlags(flags),
		.maskWrite(stb[MW]), .maskIn(mskIn), .interruptMaskReg(mask),
		.polarityWrite(stb[PW]), .polarityLowIn(polIn), .interruptOut(irq)
	);
	rtcwd_host host (.clock(clock), .rst_n(rst_n), .svcEn(svcEn),
		.svcGap(svcGap), .resetOut(resetOut), .watchdogService(svc));
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic pulse(input int k);
		stb[k] = 1'b1;
		@(negedge clock);
		stb[k] = 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// clock and crystal, four clocks per crystal period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		xtalIn = 1'b0;
		forever begin
			repeat (2) @(negedge clock);
			xtalIn = ~xtalIn;
		end
	end
	// tests need some 20000 cycles; cut a hang at 60000
	initial begin
		#480000;
		fail_count++;
		wrap_up();
	end
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{secIn, subIn, almIn, almEnIn, wdEnIn, dLow, pLow} = '0;
		{hysIn, polIn, clr, mskIn, svcEn, stb, rst_n} = '0;
		pin = 1'b1;                          // idle high, pulled up
		svcGap = 16'h00c8;
		rnd = 16'h0021;
		fail_count = 0;
		checks = 0;
		repeat (6) @(negedge clock);
		chk(mask, 6'h01);
		chk({irq, resetOut, flags}, 8'h40);
		rst_n = 1'b1;
		for (n = 0; resetOut !== 1'b0 && n < 500; n++)
			@(negedge clock);
		chk(n >= 2 * TK && n <= 4 * TK + 4, 1'b1);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			s = {rnd, lfsr(rnd)};
			b = (i == 0) ? 8'hff : rnd[7:0];
			secIn = s;
			subIn = b;
			pulse(TW);
			chk({timeSec, timeSub}, {s, b});
			for (n = 0; timeSub === b && n < 40; n++)
				@(negedge clock);
			chk({timeSec, timeSub}, (b == 8'hff) ? {s + 32'h1, 8'h00}
				: {s, b + 8'h01});
		end
		$display("time test done");
		rnd = lfsr(rnd);
		secIn = {rnd, rnd};
		subIn = 8'hfc;
		pulse(TW);
		almIn = secIn[19:0] + 20'h1;
		pulse(AMW);
		chk(almOut, almIn);
		almEnIn = 1'b1;
		pulse(AEW);
		mskIn = 6'h02;
		pulse(MW);
		pulse(SLP);
		chk({alarmEnable, sleepMode}, 2'b11);
		for (n = 0; flags[1] !== 1'b1 && n < 200; n++)
			@(negedge clock);
		@(negedge clock);
		chk({flags[1], alarmEnable, sleepMode, irq}, 4'h9);
		clr = 6'h02;
		@(negedge clock);
		clr = 6'h00;
		repeat (2) @(negedge clock);
		chk({flags[1], irq}, 2'b00);
		$display("alarm test done");
		foreach (srcList[k]) begin
			mskIn = 6'h01 << srcList[k];
			pulse(MW);
			case (srcList[k])
				0: pulse(CNV);
				2: pin = 1'b1;
				3: pin = 1'b0;
				4: dLow = 1'b1;
				default: pLow = 1'b1;
			endcase
			repeat (3) @(negedge clock);
			{dLow, pLow} = 2'b00;
			repeat (3) @(negedge clock);
			chk({flags, irq}, {mskIn, 1'b1});
			polIn = 1'b1;
			pulse(PW);
			@(negedge clock);
			chk(irq, 1'b0);
			clr = 6'h3f;
			@(negedge clock);
			clr = 6'h00;
			repeat (2) @(negedge clock);
			chk(irq, 1'b1);
			polIn = 1'b0;
			pulse(PW);
		end
		for (int h = 0; h < 2; h++) begin
			hysIn = h[0];
			pulse(SCW);
			chk(hysOut, hysIn);
		end
		$display("interrupt test done");
		while (resetOut !== 1'b0) @(negedge clock);
		rnd = lfsr(rnd);
		svcGap = {6'h00, rnd[9:0]} + 16'h0064;
		svcEn = 1'b1;
		wdEnIn = 1'b1;
		pulse(WEW);
		chk(wdBit, 1'b1);
		for (int j = 0; j < 2; j++) begin
			n = 0;
			repeat (5000) begin
				@(negedge clock);
				n += (resetOut !== 1'b0);
			end
			chk(n, 0);
			svcGap = 16'h076c;
		end
		while (svc !== 1'b1) @(negedge clock);
		svcEn = 1'b0;
		for (n = 0; resetOut !== 1'b1 && n < 4000; n++)
			@(negedge clock);
		chk(n >= 127 * TK && n <= 194 * TK, 1'b1);
		for (m = 0; resetOut !== 1'b0 && m < 200; m++)
			@(negedge clock);
		chk(m >= TK && m <= 3 * TK + 2, 1'b1);
		wdEnIn = 1'b0;
		pulse(WEW);
		chk(wdBit, 1'b0);
		n = 0;
		repeat (3500) begin
			@(negedge clock);
			n += (resetOut !== 1'b0);
		end
		chk(n, 0);
		$display("watchdog test done");
		wrap_up();
	end
endmodule
`default_nettype wire

// >>> tb/rtcwd_top_sva.sv
// assertion checker for the rtc, alarm, watchdog and irq block
`timescale 1ns/100ps
`default_nettype none
module rtcwd_chk #(
	parameter int XTAL_DIV = 4                // crystal edges per tick
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// time and alarm
	input wire logic        xtalIn,
	input wire logic        timeWrite,
	input wire logic [31:0] timeSecIn,
	input wire logic [7:0]  timeSubIn,
	input wire logic [31:0] timeSec,
	input wire logic [7:0]  timeSub,
	input wire logic [19:0] alarmSecondsMatch,
	input wire logic        alarmEnable,
	input wire logic        sleepMode,
	// watchdog and supervisors
	input wire logic        watchdogService,
	input wire logic        watchdogEnableBit,
	input wire logic        digitalSupplyLow,
	input wire logic        pumpOutputLow,
	input wire logic        resetOut,
	// interrupt
	input wire logic        conversionReady,
	input wire logic        userPin,
	input wire logic [5:0]  statusClear,
	input wire logic [5:0]  statusFlags,
	input wire logic [5:0]  interruptMaskReg,
	input wire logic        polarityWrite,
	input wire logic        polarityLowIn,
	input wire logic        interruptOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ------------------------------
	// helper state
	// ------------------------------
	localparam int WLO = 127 * XTAL_DIV;      // two quarters less a tick
	localparam int WHI = 194 * XTAL_DIV;      // three quarters plus slack
	logic        polQ;                        // mirrored polarity
	logic        xPrev;                       // last crystal level
	logic        wdOk;                        // no time load since service
	int unsigned wdCnt;                       // crystal edges since service
	// polarity mirror
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			polQ <= 1'b0;
		end else if (polarityWrite) begin
			polQ <= polarityLowIn;
		end
	end
	// crystal edges since last service, zero while disabled
	always_ff @(posedge clock) begin
		xPrev <= xtalIn;
		if (!rst_n || watchdogService || !watchdogEnableBit) begin
			wdCnt <= 0;
		end else if (xtalIn && !xPrev) begin
			wdCnt <= wdCnt + 1;
		end
	end
	// a time load shifts quarter boundaries, so that window is skipped
	always_ff @(posedge clock) begin
		if (!rst_n || timeWrite) begin
			wdOk <= 1'b0;
		end else if (watchdogService || !watchdogEnableBit) begin
			wdOk <= 1'b1;
		end
	end
	// ------------------------------
	// properties
	// ------------------------------
	sequence s_fire;
		alarmEnable && (alarmSecondsMatch == timeSec[19:0]);
	endsequence
	sequence s_fired;
		statusFlags[1] && !alarmEnable && !sleepMode;
	endsequence
	sequence s_step;
		$past(rst_n) && !$past(timeWrite) && (timeSub != $past(timeSub));
	endsequence
	a_alarm_fires: assert property (
		s_fire |=> s_fired) else $error("alarm match not handled");
	a_time_load: assert property (
		timeWrite |=> timeSec == $past(timeSecIn) &&
		timeSub == $past(timeSubIn)) else $error("time load lost");
	a_sub_step: assert property (
		s_step |-> timeSub == $past(timeSub) + 8'h01)
		else $error("subsecond jumped");
	a_sec_carry: assert property (
		s_step and timeSub == 8'h00 |-> timeSec == $past(timeSec) + 32'h1)
		else $error("seconds carry wrong");
	a_flags_stick: assert property (
		$past(rst_n) |-> (statusFlags & $past(statusFlags & ~statusClear))
		== $past(statusFlags & ~statusClear)) else $error("flag dropped");
	a_irq_gate: assert property (
		$past(rst_n) |-> interruptOut ==
		((|$past(statusFlags & interruptMaskReg)) ^ $past(polQ)))
		else $error("interrupt level wrong");
	a_supply_low: assert property (
		digitalSupplyLow |=> resetOut && statusFlags[4])
		else $error("supply low not handled");
	a_pump_low: assert property (
		pumpOutputLow |=> statusFlags[5]) else $error("pump flag missing");
	a_conv_flag: assert property (
		conversionReady |=> statusFlags[0]) else $error("conv flag missing");
	a_pin_rise: assert property (
		$past(rst_n) && $rose(userPin) |=> statusFlags[2])
		else $error("rise flag missing");
	a_pin_fall: assert property (
		$past(rst_n) && $fell(userPin) |=> statusFlags[3])
		else $error("fall flag missing");
	a_wd_window: assert property (
		$past(rst_n) && $rose(resetOut) && !$past(digitalSupplyLow) && wdOk
		|-> wdCnt >= WLO && wdCnt <= WHI) else $error("watchdog timing");
endmodule
bind rtcwd_top rtcwd_chk #(.XTAL_DIV(XTAL_DIV)) chk (
	.clock(clock), .rst_n(rst_n), .xtalIn(xtalIn), .timeWrite(timeWrite),
	.timeSecIn(timeSecIn), .timeSubIn(timeSubIn), .timeSec(timeSec),
	.timeSub(timeSub), .alarmSecondsMatch(alarmSecondsMatch),
	.alarmEnable(alarmEnable), .sleepMode(sleepMode),
	.watchdogService(watchdogService), .resetOut(resetOut),
	.watchdogEnableBit(watchdogEnableBit), .pumpOutputLow(pumpOutputLow),
	.digitalSupplyLow(digitalSupplyLow), .conversionReady(conversionReady),
	.userPin(userPin), .statusClear(statusClear), .statusFlags(statusFlags),
	.interruptMaskReg(interruptMaskReg), .polarityWrite(polarityWrite),
	.polarityLowIn(polarityLowIn), .interruptOut(interruptOut)
);
`default_nettype wire

// >>> verilog/rtcwd_divider.sv
// strobe divider: one output pulse per DIV input strobes
`timescale 1ns/100ps
`default_nettype none
module rtcwd_divider #(
	parameter int DIV = 128                 // strobes per output pulse
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// strobes
	input  wire logic strobeIn,
	output logic      pulseOut
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;  // counter width
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);    // terminal count

	// ------------------------------
	// elaboration check
	// ------------------------------
	if (DIV < 2) begin : g_bad
		$error("rtcwd_divider: DIV must be at least 2");
	end

	logic [CW-1:0] count_q;                  // strobes seen this period

	// count strobes, wrap at the terminal count
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (strobeIn) begin
			count_q <= (count_q == LAST) ? '0 : count_q + 1'b1;
		end
	end

	// pulse on the strobe that wraps the counter
	assign pulseOut = strobeIn && (count_q == LAST);
endmodule
`default_nettype wire

// >>> verilog/rtcwd_sticky.sv
// bank of sticky event flags, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module rtcwd_sticky #(
	parameter int W = 6                     // number of flags
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// events and clears
	input  wire logic [W-1:0] setIn,
	input  wire logic [W-1:0] clearIn,
	// flags
	output logic      [W-1:0] flags_q
);
	// ------------------------------
	// elaboration check
	// ------------------------------
	if (W < 1) begin : g_bad
		$error("rtcwd_sticky: W must be at least 1");
	end

	// a flag holds until cleared; a same-cycle event keeps it set
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~clearIn) | setIn;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/rtcwd_top.sv
// real-time clock with alarm, watchdog, supervisor and interrupt logic
//
// Contract
// - seconds counter 32 bits, subsecond 8 bits
// - 256 Hz tick from crystal drives subseconds
// - subsecond wrap increments seconds counter
// - time moves as full 40 bits only
// - alarm flag on 20-bit seconds match
// - alarm firing clears alarm enable itself
// - alarm match wakes device from sleep
// - watchdog enable bit starts and stops it
// - unserviced 500ms watchdog pulses reset 250ms
// - watchdog timeout lands between 500 and 750ms
// - low digital supply asserts reset, sets flag
// - hold reset 1.5s after supply recovers
// - low pump output sets its status flag
// - pump monitor selectable as interrupt source
// - interrupt is status gated by mask
// - reset: only conversion unmasked, active high
// - interrupt polarity software selectable
// - sources: pin edges, alarm, conversion, supervisors
// - hysteresis select bit drives supply monitor
`timescale 1ns/100ps
`default_nettype none
module rtcwd_top #(
	parameter int XTAL_DIV  = rtcwd_pkg::XTAL_DIV,   // crystal edges/tick
	parameter int POR_TICKS = rtcwd_pkg::POR_TICKS,  // release delay
	parameter int WRST_TICKS = rtcwd_pkg::WRST_TICKS // watchdog pulse
) (
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             rst_n,
	// crystal oscillator level
	input  wire logic                             xtalIn,
	// time load, all 40 bits at once
	input  wire logic                             timeWrite,
	input  wire logic [rtcwd_pkg::SEC_W-1:0]      timeSecIn,
	input  wire logic [rtcwd_pkg::SUB_W-1:0]      timeSubIn,
	// time readback
	output logic      [rtcwd_pkg::SEC_W-1:0]      timeSec,
	output logic      [rtcwd_pkg::SUB_W-1:0]      timeSub,
	// alarm
	input  wire logic                             alarmMatchWrite,
	input  wire logic [rtcwd_pkg::ALARM_W-1:0]    alarmMatchIn,
	input  wire logic                             alarmEnableWrite,
	input  wire logic                             alarmEnableIn,
	output logic      [rtcwd_pkg::ALARM_W-1:0]    alarmSecondsMatch,
	output logic                                  alarmEnable,
	// sleep control
	input  wire logic                             sleepEnter,
	output logic                                  sleepMode,
	// watchdog
	input  wire logic                             watchdogEnableWrite,
	input  wire logic                             watchdogEnableIn,
	input  wire logic                             watchdogService,
	output logic                                  watchdogEnableBit,
	// supervisors
	input  wire logic                             digitalSupplyLow,
	input  wire logic                             pumpOutputLow,
	input  wire logic                             supervisorConfigWrite,
	input  wire logic                             hysteresisSelectIn,
	output logic                                  hysteresisSelect,
	output logic                                  resetOut,
	// interrupt sources
	input  wire logic                             conversionReady,
	input  wire logic                             userPin,
	// status, mask and polarity
	input  wire logic [rtcwd_pkg::ST_W-1:0]       statusClear,
	output logic      [rtcwd_pkg::ST_W-1:0]       statusFlags,
	input  wire logic                             maskWrite,
	input  wire logic [rtcwd_pkg::ST_W-1:0]       maskIn,
	output logic      [rtcwd_pkg::ST_W-1:0]       interruptMaskReg,
	input  wire logic                             polarityWrite,
	input  wire logic                             polarityLowIn,
	output logic                                  interruptOut
);
	// ------------------------------
	// elaboration checks
	// ------------------------------
	if (XTAL_DIV < 2) begin : g_bad_div
		$error("rtcwd_top: XTAL_DIV must be at least 2");
	end
	if (POR_TICKS < 1 || POR_TICKS > 511) begin : g_bad_por
		$error("rtcwd_top: POR_TICKS must be 1..511");
	end
	if (WRST_TICKS < 1 || WRST_TICKS > 127) begin : g_bad_wrst
		$error("rtcwd_top: WRST_TICKS must be 1..127");
	end

	localparam int SEC_W   = rtcwd_pkg::SEC_W;    // seconds width
	localparam int SUB_W   = rtcwd_pkg::SUB_W;    // subsecond width
	localparam int ALARM_W = rtcwd_pkg::ALARM_W;  // alarm width
	localparam int ST_W    = rtcwd_pkg::ST_W;     // status width
	localparam logic [8:0] POR_LOAD  = 9'(POR_TICKS);
	localparam logic [6:0] WRST_LOAD = 7'(WRST_TICKS);
	localparam logic [1:0] WDOG_LAST = 2'(rtcwd_pkg::WDOG_QTRS);
	localparam logic [5:0] QTR_LAST  = 6'(rtcwd_pkg::QTR_TICKS - 1);

	// ------------------------------
	// crystal edge and 256 Hz tick
	// ------------------------------
	logic xtalPrev_q;                        // crystal level last cycle
	logic xtalEdge;                          // crystal rising edge
	logic tick;                              // 256 Hz tick pulse

	// remember the crystal level for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			xtalPrev_q <= 1'b0;
		end else begin
			xtalPrev_q <= xtalIn;
		end
	end

	assign xtalEdge = xtalIn && !xtalPrev_q;

	// divide crystal edges down to the subsecond tick
	rtcwd_divider #(
		.DIV      (XTAL_DIV)
	) u_tickDiv (
		.clock    (clock),
		.rst_n    (rst_n),
		.strobeIn (xtalEdge),
		.pulseOut (tick)
	);

	// ------------------------------
	// time counters
	// ------------------------------
	logic [SEC_W-1:0] sec_q;                 // seconds count
	logic [SUB_W-1:0] sub_q;                 // subsecond count
	logic             secStep;               // once-per-second step

	assign secStep = tick && (sub_q == '1);

	// subsecond counter, loaded only with the full time word
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sub_q <= '0;
		end else if (timeWrite) begin
			sub_q <= timeSubIn;
		end else if (tick) begin
			sub_q <= sub_q + 1'b1;
		end
	end

	// seconds counter, steps on subsecond wrap
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sec_q <= '0;
		end else if (timeWrite) begin
			sec_q <= timeSecIn;
		end else if (secStep) begin
			sec_q <= sec_q + 1'b1;
		end
	end

	// readback always presents one coherent 40-bit pair
	assign timeSec = sec_q;
	assign timeSub = sub_q;

	// ------------------------------
	// time-of-day alarm
	// ------------------------------
	logic [ALARM_W-1:0] alarmMatch_q;        // alarm_seconds_match
	logic               alarmEnable_q;       // alarm_enable
	logic               alarmFire;           // match while enabled

	// host-loaded match value, expected 1s to 12 days ahead
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alarmMatch_q <= '0;
		end else if (alarmMatchWrite) begin
			alarmMatch_q <= alarmMatchIn;
		end
	end

	assign alarmFire = alarmEnable_q &&
		(alarmMatch_q == sec_q[ALARM_W-1:0]);

	// enable bit; firing clears it and wins over a host write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alarmEnable_q <= 1'b0;
		end else if (alarmFire) begin
			alarmEnable_q <= 1'b0;
		end else if (alarmEnableWrite) begin
			alarmEnable_q <= alarmEnableIn;
		end
	end

	assign alarmSecondsMatch = alarmMatch_q;
	assign alarmEnable       = alarmEnable_q;

	// ------------------------------
	// sleep mode
	// ------------------------------
	logic sleep_q;                           // device asleep

	// alarm wake wins over a same-cycle sleep request
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sleep_q <= 1'b0;
		end else if (alarmFire) begin
			sleep_q <= 1'b0;
		end else if (sleepEnter) begin
			sleep_q <= 1'b1;
		end
	end

	assign sleepMode = sleep_q;

	// ------------------------------
	// watchdog
	// ------------------------------
	logic       wdEnable_q;                  // watchdog_enable_bit
	logic [1:0] wdQtrs_q;                    // quarter-seconds unserviced
	logic       qtrTick;                     // free-running 4 Hz tick
	logic       wdTimeout;                   // watchdog expired
	logic [6:0] wdPulse_q;                   // reset pulse ticks left

	// enable bit written directly by the host
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wdEnable_q <= 1'b0;
		end else if (watchdogEnableWrite) begin
			wdEnable_q <= watchdogEnableIn;
		end
	end

	// quarter ticks run from the free subsecond phase, not the service
	assign qtrTick   = tick && (sub_q[5:0] == QTR_LAST);
	assign wdTimeout = wdEnable_q && qtrTick &&
		(wdQtrs_q == WDOG_LAST) && !watchdogService;

	// count quarter ticks since the last service write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wdQtrs_q <= '0;
		end else if (!wdEnable_q || watchdogService) begin
			wdQtrs_q <= '0;
		end else if (wdTimeout) begin
			wdQtrs_q <= '0;
		end else if (qtrTick) begin
			wdQtrs_q <= wdQtrs_q + 1'b1;
		end
	end

	// reset pulse length counter
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wdPulse_q <= '0;
		end else if (wdTimeout) begin
			wdPulse_q <= WRST_LOAD;
		end else if (tick && wdPulse_q != '0) begin
			wdPulse_q <= wdPulse_q - 1'b1;
		end
	end

	assign watchdogEnableBit = wdEnable_q;

	// ------------------------------
	// supply supervisor and reset output
	// ------------------------------
	logic [8:0] por_q;                       // release ticks left
	logic       hys_q;                       // hysteresis_select
	logic       resetOut_q;                  // registered reset output

	// release timer restarts while the supply is low
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			por_q <= POR_LOAD;
		end else if (digitalSupplyLow) begin
			por_q <= POR_LOAD;
		end else if (tick && por_q != '0) begin
			por_q <= por_q - 1'b1;
		end
	end

	// supervisor configuration bit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hys_q <= rtcwd_pkg::HYS_RST;
		end else if (supervisorConfigWrite) begin
			hys_q <= hysteresisSelectIn;
		end
	end

	assign hysteresisSelect = hys_q;

	// reset out: supply low, release delay or watchdog pulse
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			resetOut_q <= 1'b1;
		end else begin
			resetOut_q <= digitalSupplyLow || (por_q != '0) ||
				(wdPulse_q != '0);
		end
	end

	assign resetOut = resetOut_q;

	// ------------------------------
	// status flags
	// ------------------------------
	logic            pinPrev_q;              // user_pin last cycle
	logic [ST_W-1:0] events;                 // this cycle's events

	// remember the pin for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinPrev_q <= 1'b1;               // pin idles pulled high
		end else begin
			pinPrev_q <= userPin;
		end
	end

	// gather sources into their status positions
	always_comb begin
		events = '0;
		events[rtcwd_pkg::ST_CONV]     = conversionReady;
		events[rtcwd_pkg::ST_ALARM]    = alarmFire;
		events[rtcwd_pkg::ST_PIN_RISE] = userPin && !pinPrev_q;
		events[rtcwd_pkg::ST_PIN_FALL] = !userPin && pinPrev_q;
		events[rtcwd_pkg::ST_DSUP_LOW] = digitalSupplyLow;
		events[rtcwd_pkg::ST_PUMP_LOW] = pumpOutputLow;
	end

	// sticky flags, cleared by writing ones
	rtcwd_sticky #(
		.W       (ST_W)
	) u_status (
		.clock   (clock),
		.rst_n   (rst_n),
		.setIn   (events),
		.clearIn (statusClear),
		.flags_q (statusFlags)
	);

	// ------------------------------
	// interrupt mask, polarity and output
	// ------------------------------
	logic [ST_W-1:0] mask_q;                 // interrupt_mask_reg
	logic            polLow_q;               // output active low
	logic            irq_q;                  // registered interrupt

	// mask register, only conversion unmasked out of reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_q <= rtcwd_pkg::MASK_RST;
		end else if (maskWrite) begin
			mask_q <= maskIn;
		end
	end

	// polarity select, active high out of reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			polLow_q <= rtcwd_pkg::POL_RST;
		end else if (polarityWrite) begin
			polLow_q <= polarityLowIn;
		end
	end

	// any unmasked flag asserts the output at the chosen level
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|(statusFlags & mask_q)) ^ polLow_q;
		end
	end

	assign interruptMaskReg = mask_q;
	assign interruptOut     = irq_q;
endmodule
`default_nettype wire
